// ===== pos_sup_pkg.sv
package pos_sup_pkg;
   localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
   localparam logic [31:0] ADDR_GEAR_NUM = 32'h0000_0004;
   localparam logic [31:0] ADDR_GEAR_DEN = 32'h0000_0008;
   localparam logic [31:0] ADDR_SCURVE = 32'h0000_000C;
   localparam logic [31:0] ADDR_ROUGH = 32'h0000_0010;
   localparam logic [31:0] ADDR_LIM_POS = 32'h0000_0014;
   localparam logic [31:0] ADDR_LIM_NEG = 32'h0000_0018;
   localparam logic [31:0] ADDR_MOVE = 32'h0000_001C;
   localparam logic [31:0] ADDR_STATUS = 32'h0000_0020;
   localparam logic [31:0] ADDR_IRQ_STAT = 32'h0000_0024;
   localparam logic [31:0] ADDR_IRQ_MASK = 32'h0000_0028;
   localparam logic [31:0] ADDR_POSITION = 32'h0000_002C;
   localparam logic [31:0] ADDR_ERR_LVL = 32'h0000_0030;
   localparam logic [31:0] ADDR_ERR_UNIT = 32'h0000_0034;
   localparam int CTRL_STOP_PAT = 0;
   localparam int CTRL_HOMING = 1;
   localparam int CTRL_NEW_VER = 2;
   localparam int CTRL_MULT_LSB = 4;
   localparam int IRQ_FINISH = 0;
   localparam int IRQ_ROUGH = 1;
   localparam int IRQ_LIMIT = 2;
   localparam int IRQ_ALARM = 3;
   localparam int IRQ_BITS = 4;
   localparam logic [15:0] GEAR_NUM_RESET = 16'h0001;
   localparam logic [15:0] GEAR_DEN_RESET = 16'h0001;
   localparam logic [15:0] ERR_LVL_RESET = 16'h0050;
   localparam logic [7:0] ALARM_PARAM = 8'h37;
   localparam logic [15:0] UNIT_NEW_MREV = 16'h0019;
   localparam logic [15:0] UNIT_OLD_MREV = 16'h0064;
   localparam int SCURVE_UNIT_NS = 1000000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int SCURVE_TICKS = SCURVE_UNIT_NS / CLK_PERIOD_NS;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   typedef enum logic [1:0] {MV_IDLE, MV_RUN, MV_SETTLE, MV_HALT} move_state_t;
   typedef struct packed {
      logic step;
      logic dir;
      logic clear_droop;
      logic servo_lock;
   } amp_cmd_t;
endpackage : pos_sup_pkg

// ===== positioning_command_supervisor.sv
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module positioning_command_supervisor
   import pos_sup_pkg::*;
#(
   parameter int SCURVE_CYCLES = SCURVE_TICKS
) (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Amplifier side
   input wire logic limit_switch_pos,
   input wire logic limit_switch_neg,
   input wire logic droop_empty,
   output amp_cmd_t amp_cmd,
   // Status outputs
   output logic movement_finished,
   output logic rough_match_flag,
   output logic [7:0] alarm_code,
   output logic irq
);
   logic [15:0] gear_numerator, gear_denominator, wr_num, wr_den;
   logic [7:0] ctrl;
   logic [15:0] scurve_ms, rough_set, error_excessive_level;
   logic signed [31:0] lim_pos, lim_neg, position;
   logic [31:0] remaining, accum;
   logic [IRQ_BITS-1:0] irq_stat, irq_mask, irq_event;
   logic [31:0] scale_cnt, addr_q;
   logic [15:0] settle_ms;
   logic wr_q, sel_q, move_go, boot, dir;
   logic [31:0] move_len;
   move_state_t state;
   logic limits_on, limit_hit, param_err;
   logic [47:0] rough_dist;
   logic soft_hit_pos, soft_hit_neg, switch_hit;
   logic rough_reached, take_xfer, clear_req;
   logic [31:0] status_word;
   logic start_move, stop_now, step_now, consume, run_done, settle_done, ms_tick;

   function automatic logic [47:0] pow10_scale(input logic [15:0] v, input logic [1:0] m);
      logic [47:0] r;
      r = {32'h0, v};
      for (int i = 0; i < 3; i++) begin
         if (i < int'(m)) begin
            r = r * 48'd10;
         end
      end
      return r;
   endfunction : pow10_scale

   // Valid single-word transfer request
   function automatic logic xfer_valid(input logic sel, input logic [1:0] trans, input logic [2:0] size);
      return sel && trans == HTRANS_NONSEQ && size == HSIZE_WORD;
   endfunction : xfer_valid

   // Write data phase aimed at one register
   function automatic logic wr_hit(input logic sel, input logic wr, input logic [31:0] a,
                                   input logic [31:0] target);
      return sel && wr && a == target;
   endfunction : wr_hit

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = |(irq_stat & irq_mask);

   // Bus request decodes
   assign take_xfer = hready && xfer_valid(hsel, htrans, hsize);
   assign clear_req = wr_hit(sel_q, wr_q, addr_q, ADDR_IRQ_STAT);

   // Address phase capture
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sel_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= 32'h0;
      end else if (hready) begin
         sel_q <= xfer_valid(hsel, htrans, hsize);
         wr_q <= hwrite;
         addr_q <= haddr;
      end
   end

   // Register writes
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl <= 8'h00;
         wr_num <= GEAR_NUM_RESET;
         wr_den <= GEAR_DEN_RESET;
         scurve_ms <= 16'h0;
         rough_set <= 16'h0;
         lim_pos <= 32'sh0;
         lim_neg <= 32'sh0;
         irq_mask <= '0;
         error_excessive_level <= ERR_LVL_RESET;
         move_go <= 1'b0;
         move_len <= 32'h0;
      end else begin
         move_go <= 1'b0;
         if (sel_q && wr_q) begin
            unique case (addr_q)
               ADDR_CTRL: ctrl <= hwdata[7:0];
               ADDR_GEAR_NUM: wr_num <= hwdata[15:0];
               ADDR_GEAR_DEN: wr_den <= hwdata[15:0];
               ADDR_SCURVE: scurve_ms <= hwdata[15:0];
               ADDR_ROUGH: rough_set <= hwdata[15:0];
               ADDR_LIM_POS: lim_pos <= hwdata;
               ADDR_LIM_NEG: lim_neg <= hwdata;
               ADDR_IRQ_MASK: irq_mask <= hwdata[IRQ_BITS-1:0];
               ADDR_ERR_LVL: error_excessive_level <= hwdata[15:0];
               ADDR_MOVE: begin
                  move_len <= hwdata;
                  move_go <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   // Power-up latch of gear values
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         boot <= 1'b1;
         gear_numerator <= GEAR_NUM_RESET;
         gear_denominator <= GEAR_DEN_RESET;
      end else if (boot) begin
         boot <= 1'b0;
         gear_numerator <= wr_num;
         gear_denominator <= wr_den;
      end
   end

   // Read mux
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hrdata <= 32'h0;
      end else if (take_xfer && !hwrite) begin
         unique case (haddr)
            ADDR_CTRL: hrdata <= {24'h0, ctrl};
            ADDR_GEAR_NUM: hrdata <= {16'h0, gear_numerator};
            ADDR_GEAR_DEN: hrdata <= {16'h0, gear_denominator};
            ADDR_SCURVE: hrdata <= {16'h0, scurve_ms};
            ADDR_ROUGH: hrdata <= {16'h0, rough_set};
            ADDR_LIM_POS: hrdata <= lim_pos;
            ADDR_LIM_NEG: hrdata <= lim_neg;
            ADDR_MOVE: hrdata <= remaining;
            ADDR_STATUS: hrdata <= status_word;
            ADDR_IRQ_STAT: hrdata <= {28'h0, irq_stat};
            ADDR_IRQ_MASK: hrdata <= {28'h0, irq_mask};
            ADDR_POSITION: hrdata <= position;
            ADDR_ERR_LVL: hrdata <= {16'h0, error_excessive_level};
            ADDR_ERR_UNIT: hrdata <= {16'h0, ctrl[CTRL_NEW_VER] ? UNIT_NEW_MREV
                                                                : UNIT_OLD_MREV};
            default: hrdata <= 32'h0;
         endcase
      end
   end

   // Parameter checks and limits
   always_comb begin
      param_err = (gear_denominator == 16'h0) || (lim_pos < lim_neg);
      limits_on = (lim_pos != lim_neg) && !ctrl[CTRL_HOMING];
      soft_hit_pos = limits_on && dir == 1'b0 && position >= lim_pos;
      soft_hit_neg = limits_on && dir && position <= lim_neg;
      switch_hit = (dir == 1'b0 && limit_switch_pos) || (dir && limit_switch_neg);
      limit_hit = soft_hit_pos || soft_hit_neg || switch_hit;
      rough_dist = pow10_scale(rough_set, ctrl[CTRL_MULT_LSB+:2]);
      rough_reached = {16'h0, remaining} <= rough_dist;
      status_word = {16'h0, alarm_code, 2'h0, state, limit_hit, rough_match_flag, movement_finished, param_err};
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         alarm_code <= 8'h00;
      end else begin
         alarm_code <= param_err ? ALARM_PARAM : 8'h00;
      end
   end

   // Sequencer decisions
   always_comb begin
      start_move = state == MV_IDLE && move_go && !param_err;
      stop_now = state == MV_RUN && (limit_hit || param_err);
      step_now = state == MV_RUN && !stop_now && accum >= {16'h0, gear_denominator};
      consume = state == MV_RUN && !stop_now && !step_now && remaining != 32'h0;
      run_done = state == MV_RUN && !stop_now && !step_now && remaining == 32'h0;
      settle_done = state == MV_SETTLE && settle_ms == 16'h0;
      ms_tick = scale_cnt == 32'(SCURVE_CYCLES - 1);
   end

   // Move state
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state <= MV_IDLE;
      end else begin
         unique case (state)
            MV_IDLE: begin
               if (start_move) begin
                  state <= MV_RUN;
               end
            end
            MV_RUN: begin
               if (stop_now) begin
                  state <= ctrl[CTRL_STOP_PAT] ? MV_HALT : MV_IDLE;
               end else if (run_done) begin
                  state <= MV_SETTLE;
               end
            end
            MV_SETTLE: begin
               if (settle_done) begin
                  state <= MV_IDLE;
               end
            end
            MV_HALT: begin
               if (droop_empty) begin
                  state <= MV_IDLE;
               end
            end
         endcase
      end
   end

   // Command count and gear accumulator
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dir <= 1'b0;
         remaining <= 32'h0;
         accum <= 32'h0;
      end else if (start_move) begin
         dir <= move_len[31];
         remaining <= move_len[31] ? 32'(-move_len) : move_len;
         accum <= 32'h0;
      end else if (stop_now) begin
         remaining <= 32'h0;
      end else if (step_now) begin
         accum <= accum - {16'h0, gear_denominator};
      end else if (consume) begin
         accum <= 32'(accum + gear_numerator);
         remaining <= remaining - 32'h1;
      end
   end

   // Commanded position
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         position <= 32'sh0;
      end else if (step_now) begin
         position <= dir ? position - 32'sd1 : position + 32'sd1;
      end
   end

   // Amplifier command
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         amp_cmd <= '0;
      end else begin
         amp_cmd.step <= step_now;
         amp_cmd.clear_droop <= stop_now && !ctrl[CTRL_STOP_PAT];
         if (step_now) begin
            amp_cmd.dir <= dir;
         end
         if (start_move) begin
            amp_cmd.servo_lock <= 1'b0;
         end else if (stop_now) begin
            amp_cmd.servo_lock <= 1'b1;
         end
      end
   end

   // Settle timer, one S-curve unit per scale period
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         settle_ms <= 16'h0;
         scale_cnt <= 32'h0;
      end else if (run_done) begin
         settle_ms <= scurve_ms;
         scale_cnt <= 32'h0;
      end else if (state == MV_SETTLE && settle_ms != 16'h0) begin
         if (ms_tick) begin
            scale_cnt <= 32'h0;
            settle_ms <= settle_ms - 16'h1;
         end else begin
            scale_cnt <= scale_cnt + 32'h1;
         end
      end
   end

   // Finish and rough-match flags
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         movement_finished <= 1'b0;
         rough_match_flag <= 1'b0;
      end else if (start_move) begin
         movement_finished <= 1'b0;
         rough_match_flag <= 1'b0;
      end else begin
         if (state == MV_RUN && !stop_now && rough_reached) begin
            rough_match_flag <= 1'b1;
         end
         if (settle_done) begin
            movement_finished <= 1'b1;
         end
      end
   end

   // Interrupt events
   always_comb begin
      irq_event = '0;
      irq_event[IRQ_FINISH] = settle_done;
      irq_event[IRQ_ROUGH] = state == MV_RUN && !stop_now && !rough_match_flag && rough_reached;
      irq_event[IRQ_LIMIT] = state == MV_RUN && limit_hit;
      irq_event[IRQ_ALARM] = param_err && alarm_code == 8'h00;
   end

   // Sticky status bits, set wins over clear
   for (genvar b = 0; b < IRQ_BITS; b++) begin : g_irq_bit
      always_ff @(posedge clk_sys or posedge reset) begin
         if (reset) begin
            irq_stat[b] <= 1'b0;
         end else if (irq_event[b]) begin
            irq_stat[b] <= 1'b1;
         end else if (clear_req && hwdata[b]) begin
            irq_stat[b] <= 1'b0;
         end
      end
   end
endmodule : positioning_command_supervisor
`default_nettype wire

// ===== pos_sup_props.sv
`timescale 1ns/1ps
`default_nettype none
module pos_sup_props
   import pos_sup_pkg::*;
(
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // Motion
   input wire amp_cmd_t amp_cmd,
   input wire logic movement_finished,
   input wire logic rough_match_flag,
   input wire logic [7:0] alarm_code
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic mv_wr;
   assign mv_wr = hsel && hready && htrans == HTRANS_NONSEQ && hwrite && haddr == ADDR_MOVE;
   a_bus_always_ok: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
   a_alarm_code_value: assert property (alarm_code == 8'h00 || alarm_code == ALARM_PARAM)
      else $error("alarm code not 0 or 37");
   a_alarm_no_step: assert property (alarm_code != 8'h00 |-> !amp_cmd.step)
      else $error("step during parameter error");
   a_lock_no_step: assert property (amp_cmd.servo_lock |-> !amp_cmd.step)
      else $error("step while servo locked");
   a_clear_one_cycle: assert property (amp_cmd.clear_droop |=> !amp_cmd.clear_droop)
      else $error("droop clear longer than one cycle");
   a_clear_with_lock: assert property (amp_cmd.clear_droop |-> ##[0:1] amp_cmd.servo_lock)
      else $error("droop clear without servo lock");
   a_move_clears_finish: assert property (mv_wr && movement_finished && alarm_code == 8'h00
      |-> ##[2:3] !movement_finished)
      else $error("finished not cleared by new move");
   a_finish_has_rough: assert property (movement_finished |-> rough_match_flag)
      else $error("finished without rough match");
   c_step: cover property (amp_cmd.step);
   c_clear: cover property (amp_cmd.clear_droop);
   c_finish: cover property ($rose(movement_finished));
endmodule : pos_sup_props
bind positioning_command_supervisor pos_sup_props u_pos_sup_props (.clk_sys, .reset, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hreadyout, .hresp, .amp_cmd, .movement_finished, .rough_match_flag,
   .alarm_code);
`default_nettype wire

// ===== amp_model.sv
`timescale 1ns/1ps
`default_nettype none
module amp_model
   import pos_sup_pkg::*;
#(
   parameter int SLOW_DIV = 8
) (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Command side
   input wire amp_cmd_t amp_cmd,
   input wire logic slow,
   // Loop state
   output logic droop_empty,
   output logic signed [31:0] position
);
   int droop;
   int div;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         droop <= 0;
         div <= 0;
         position <= 32'sh0;
      end else begin
         div <= (div == SLOW_DIV - 1) ? 0 : div + 1;
         if (amp_cmd.step)
            position <= amp_cmd.dir ? position - 32'sd1 : position + 32'sd1;
         if (amp_cmd.clear_droop)
            droop <= 0;
         else if (amp_cmd.step)
            droop <= droop + 1;
         else if (droop > 0 && (!slow || div == 0))
            droop <= droop - 1;
      end
   end
   assign droop_empty = (droop == 0);
endmodule : amp_model
`default_nettype wire

// ===== positioning_command_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module positioning_command_supervisor_tb;
   import pos_sup_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic lim_p = 1'b0;
   logic lim_n = 1'b0;
   logic slow = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, droop_empty, fin, rough, irq;
   logic [7:0] alarm;
   amp_cmd_t amp_cmd;
   logic signed [31:0] position;
   int clears = 0;
   int fail_count = 0;
   int cmp_count = 0;
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (amp_cmd.clear_droop === 1'b1) clears <= clears + 1;
   positioning_command_supervisor #(.SCURVE_CYCLES(4)) u_positioning_command_supervisor (.clk_sys, .reset,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .limit_switch_pos(lim_p), .limit_switch_neg(lim_n), .droop_empty, .amp_cmd, .movement_finished(fin),
      .rough_match_flag(rough), .alarm_code(alarm), .irq);
   amp_model u_amp_model (.clk_sys, .reset, .amp_cmd, .slow, .droop_empty, .position);
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask : wr
   task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      chk(n, e, q);
   endtask : rc
   task automatic wt(input int k, output int t);
      t = 0;
      while (t < 3000 && (k == 0 ? fin : k == 1 ? rough : k == 2 ? amp_cmd.servo_lock : droop_empty) !== 1'b1) begin
         @(posedge clk_sys);
         t++;
      end
      chk("wait", 32'h1, t < 3000);
   endtask : wt
   task automatic go(input logic [31:0] n, input int k, output int t);
      wr(ADDR_MOVE, n);
      repeat (2) @(posedge clk_sys);
      chk("finish clear", 32'h0, fin);
      chk("rough clear", 32'h0, rough);
      wt(k, t);
   endtask : go
   task automatic t_regs;
      chk("alarm", 32'h0, alarm);
      wr(ADDR_GEAR_NUM, 32'h3);
      rc("gear num", ADDR_GEAR_NUM, 32'h1);
      rc("gear den", ADDR_GEAR_DEN, 32'h1);
      rc("err level", ADDR_ERR_LVL, 32'h50);
      rc("unit old", ADDR_ERR_UNIT, 32'h64);
      wr(ADDR_CTRL, 32'h4);
      rc("unit new", ADDR_ERR_UNIT, 32'h19);
      rc("unmapped", 32'h40, 32'h0);
   endtask : t_regs
   task automatic t_move;
      int p;
      int t;
      p = position;
      go(32'h14, 0, t);
      chk("travel", p + 20, position);
      chk("rough end", 32'h1, rough);
      chk("masked irq", 32'h0, irq);
      rc("irq stat", ADDR_IRQ_STAT, 32'h3);
      wr(ADDR_IRQ_MASK, 32'h1);
      @(posedge clk_sys);
      chk("irq", 32'h1, irq);
      wr(ADDR_IRQ_STAT, 32'h3);
      @(posedge clk_sys);
      chk("irq clear", 32'h0, irq);
   endtask : t_move
   task automatic t_rough;
      int t;
      wr(ADDR_ROUGH, 32'h5);
      go(32'h14, 1, t);
      chk("early rough", 32'h0, fin);
      wt(0, t);
      wr(ADDR_ROUGH, 32'h0);
   endtask : t_rough
   task automatic t_scurve;
      int t0;
      int t1;
      go(32'h14, 0, t0);
      wr(ADDR_SCURVE, 32'h2);
      go(32'h14, 0, t1);
      chk("s delay", 32'h8, t1 - t0);
      wr(ADDR_SCURVE, 32'h0);
   endtask : t_scurve
   task automatic t_limits;
      int p;
      int c;
      int t;
      wr(ADDR_LIM_POS, 32'h1);
      wr(ADDR_LIM_NEG, 32'h5);
      repeat (2) @(posedge clk_sys);
      chk("alarm", ALARM_PARAM, alarm);
      wr(ADDR_LIM_POS, 32'h0);
      wr(ADDR_LIM_NEG, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk("no alarm", 32'h0, alarm);
      go(32'h14, 0, t);
      p = position;
      wr(ADDR_LIM_POS, p + 10);
      wr(ADDR_CTRL, 32'h2);
      go(32'h14, 0, t);
      chk("homing", p + 20, position);
      wr(ADDR_LIM_POS, p + 40);
      wr(ADDR_CTRL, 32'h0);
      c = clears;
      go(32'h64, 2, t);
      @(posedge clk_sys);
      chk("sudden stop", 32'h1, clears > c);
      chk("inside", 32'h1, position <= p + 40);
      wr(ADDR_LIM_POS, 32'h0);
      wr(ADDR_CTRL, 32'h1);
      slow <= 1'b1;
      c = clears;
      wr(ADDR_MOVE, 32'hFFFF_FF9C);
      repeat (20) @(posedge clk_sys);
      lim_n <= 1'b1;
      wt(2, t);
      wt(3, t);
      chk("slow stop", c, clears);
      lim_n <= 1'b0;
      slow <= 1'b0;
   endtask : t_limits
   task automatic complete_run;
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      t_regs;
      t_move;
      t_rough;
      t_scurve;
      t_limits;
      complete_run;
   end
   initial begin
      #200000;
      fail_count++;
      complete_run;
   end
endmodule : positioning_command_supervisor_tb
`default_nettype wire
